/* include/rcinit_pkg.sv */
// package for the reset cause and initial value block
package rcinit_pkg;

	localparam int unsigned PC_W = 13;
	localparam int unsigned EVT_W = 5;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_STATUS = 8'h03;
	localparam logic [7:0] IDX_CAUSE = 8'h8e;
	localparam logic [7:0] IDX_CORE_IRQ = 8'h0b;
	localparam logic [7:0] IDX_PIRQ_A = 8'h0c;
	localparam logic [7:0] IDX_PIRQ_B = 8'h0d;
	localparam logic [7:0] IDX_OPTION = 8'h81;
	localparam logic [7:0] IDX_DIR_A = 8'h85;
	localparam logic [7:0] IDX_DIR_B = 8'h86;
	localparam logic [7:0] IDX_DIR_C = 8'h87;
	localparam logic [7:0] IDX_PERIOD = 8'h92;
	localparam logic [7:0] IDX_BIRQ_F = 8'ha0;
	localparam logic [7:0] IDX_BIRQ_E = 8'ha1;
	localparam logic [7:0] IDX_BERR_F = 8'ha2;
	localparam logic [7:0] IDX_BERR_E = 8'ha3;
	localparam logic [7:0] IDX_EVT_ST = 8'hc0;
	localparam logic [7:0] IDX_EVT_MASK = 8'hc1;

	// field positions
	localparam int unsigned ST_TIMEOUT = 4;
	localparam int unsigned ST_POWERDOWN = 3;
	localparam int unsigned CS_POWER_ON = 1;
	localparam int unsigned CS_BROWNOUT = 0;
	localparam int unsigned CI_GLOBAL_EN = 7;

	// reset and initial values
	localparam logic [7:0] STATUS_INIT = 8'h18;
	localparam logic [1:0] CAUSE_INIT = 2'h0;
	localparam logic [7:0] ONES_INIT = 8'hff;
	localparam logic [7:0] ZERO_INIT = 8'h00;
	localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
	localparam logic [PC_W-1:0] PC_VECTOR = 13'h0004;

	typedef struct packed {
		logic wake;
		logic dog;
		logic clear;
		logic brownout;
		logic power_on;
	} rcinit_evt_t;

	typedef enum {
		C_NONE,
		C_POWER_ON,
		C_BROWNOUT,
		C_CLEAR_RUN,
		C_CLEAR_SLEEP,
		C_DOG_RUN,
		C_DOG_SLEEP,
		C_IRQ_WAKE
	} rcinit_cause_t;

	// a hardware set wins over a software write in the same cycle
	function automatic logic [7:0] rcinit_sticky(input logic [7:0] q, input logic wr,
			input logic [7:0] wdat, input logic [7:0] set);
		rcinit_sticky = (wr ? wdat : q) | set;
	endfunction : rcinit_sticky

endpackage : rcinit_pkg

/* hdl/rcinit_sync.sv */
// three flop synchroniser that accepts a change once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module rcinit_sync #(
	parameter int unsigned W = 4
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] level_o
);

	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] level_q;
	logic [W-1:0] agree;

	assign agree = ~(s2_q ^ s3_q);
	assign level_o = level_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			level_q <= '0;
		end else begin
			s1_q <= async_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			level_q <= (agree & s3_q) | (~agree & level_q);
		end
	end

endmodule : rcinit_sync
`default_nettype wire

/* hdl/rcinit_cause.sv */
// picks the one cause that applies this cycle from the source events
`timescale 1ns/100ps
`default_nettype none
module rcinit_cause (
	input wire rcinit_pkg::rcinit_evt_t evt_i,
	input wire logic sleeping_i,
	output var rcinit_pkg::rcinit_cause_t cause_o
);

	// power loss outranks the pin, the pin outranks the watchdog, wake-up comes last
	always_comb begin
		cause_o = rcinit_pkg::C_NONE;
		if (evt_i.power_on) begin
			cause_o = rcinit_pkg::C_POWER_ON;
		end else if (evt_i.brownout) begin
			cause_o = rcinit_pkg::C_BROWNOUT;
		end else if (evt_i.clear) begin
			cause_o = sleeping_i ? rcinit_pkg::C_CLEAR_SLEEP : rcinit_pkg::C_CLEAR_RUN;
		end else if (evt_i.dog) begin
			cause_o = sleeping_i ? rcinit_pkg::C_DOG_SLEEP : rcinit_pkg::C_DOG_RUN;
		end else if (evt_i.wake && sleeping_i) begin
			cause_o = rcinit_pkg::C_IRQ_WAKE;
		end
	end

endmodule : rcinit_cause
`default_nettype wire

/* hdl/rcinit_top.sv */
// reset cause recorder and initial value loader with a wishbone register port
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// RULE1: power-on sets time-out, clears power-on flag, keeps brown-out, pc to zero
// RULE2: power-on also sets power-down, so power-down low with power-on low is illegal
// RULE3: master clear while running clears upper status, keeps all flags, pc zero
// RULE4: master clear in sleep sets time-out, clears power-down, upper status, pc zero
// RULE5: watchdog while running clears time-out, sets power-down, clears upper, pc zero
// RULE6: watchdog in sleep clears time-out and power-down, keeps rest, pc plus one
// RULE7: interrupt wake sets time-out, clears power-down, pc plus one or vector
// RULE8: brown-out clears brown-out flag, keeps power-on flag, clears upper, pc zero
// RULE9: other resets clear upper status, set flags per cause, keep cause register
// RULE10: interrupt flags that woke the core stay set
// RULE11: option and port direction go to all ones on resets, kept on wake
// RULE12: bus flag and enable registers clear on any cause; period goes all ones
// RULE13: cause register holds two low bits, upper six read as zero
// RULE14: software sets power-on and brown-out flags after power-on
module rcinit_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] sel_i,
	input wire logic [9:0] adr_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic power_on_i,
	input wire logic brownout_i,
	input wire logic master_clear_pin_n_i,
	input wire logic watchdog_timer_i,
	input wire logic wake_irq_i,
	input wire logic sleeping_i,
	input wire logic [rcinit_pkg::PC_W-1:0] cur_pc_i,
	input wire logic [2:0] core_flag_set_i,
	input wire logic [7:0] pirq_a_set_i,
	input wire logic pirq_b_set_i,
	input wire logic [5:0] bus_irq_set_i,
	input wire logic [7:0] bus_err_set_i,
	output logic pc_load_o,
	output logic [rcinit_pkg::PC_W-1:0] pc_value_o,
	output logic global_irq_enable_o,
	output logic [7:0] option_o,
	output logic [5:0] port_a_direction_o,
	output logic [7:0] port_b_direction_o,
	output logic [4:0] port_c_direction_o,
	output logic [7:0] timer_period_o,
	output logic irq_o
);

	logic [3:0] lvl;
	logic [3:0] lvl_prev_q;
	rcinit_pkg::rcinit_evt_t evt;
	rcinit_pkg::rcinit_cause_t cause;

	logic [7:0] status_q, status_d;
	logic [1:0] pwr_cause_q, pwr_cause_d;
	logic [7:0] core_irq_q;
	logic [7:0] pirq_a_q;
	logic pirq_b_q;
	logic [7:0] option_q;
	logic [5:0] dir_a_q;
	logic [7:0] dir_b_q;
	logic [4:0] dir_c_q;
	logic [7:0] period_q;
	logic [5:0] birq_f_q, birq_e_q;
	logic [7:0] berr_f_q, berr_e_q;
	logic [rcinit_pkg::EVT_W-1:0] evt_st_q, evt_mask_q;
	logic pc_load_q;
	logic [rcinit_pkg::PC_W-1:0] pc_q, pc_d;
	logic irq_q;
	logic ack_q;
	logic [31:0] dat_q;

	// the pin is active low; invert before sync so every level means "asserted"
	rcinit_sync #(
		.W(4)
	) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.async_i({watchdog_timer_i, ~master_clear_pin_n_i, brownout_i, power_on_i}),
		.level_o(lvl)
	);

	// one event per assertion of each synchronised source, not per cycle it is held; wake is passed through as a level
	assign evt.power_on = lvl[0] & ~lvl_prev_q[0];
	assign evt.brownout = lvl[1] & ~lvl_prev_q[1];
	assign evt.clear = lvl[2] & ~lvl_prev_q[2];
	assign evt.dog = lvl[3] & ~lvl_prev_q[3];
	assign evt.wake = wake_irq_i;

	rcinit_cause u_cause (
		.evt_i(evt),
		.sleeping_i(sleeping_i),
		.cause_o(cause)
	);

	wire logic is_any = (cause != rcinit_pkg::C_NONE);
	wire logic is_power = (cause == rcinit_pkg::C_POWER_ON) | (cause == rcinit_pkg::C_BROWNOUT);
	wire logic is_wake = (cause == rcinit_pkg::C_DOG_SLEEP) | (cause == rcinit_pkg::C_IRQ_WAKE);
	wire logic is_reset = is_any & ~is_wake;
	wire logic global_irq_enable = core_irq_q[rcinit_pkg::CI_GLOBAL_EN];
	wire logic [rcinit_pkg::PC_W-1:0] pc_next = cur_pc_i + 13'h0001;

	// bus decode; the bus takes a cycle so reads come from flops
	wire logic req = cyc_i & stb_i;
	wire logic [7:0] idx = adr_i[9:2];
	wire logic wr = req & we_i & sel_i[0] & ack_q;
	wire logic [7:0] wdat = dat_i[7:0];
	wire logic wr_status = wr & (idx == rcinit_pkg::IDX_STATUS);
	wire logic wr_cause = wr & (idx == rcinit_pkg::IDX_CAUSE);
	wire logic wr_core = wr & (idx == rcinit_pkg::IDX_CORE_IRQ);
	wire logic wr_pa = wr & (idx == rcinit_pkg::IDX_PIRQ_A);
	wire logic wr_pb = wr & (idx == rcinit_pkg::IDX_PIRQ_B);
	wire logic wr_opt = wr & (idx == rcinit_pkg::IDX_OPTION);
	wire logic wr_da = wr & (idx == rcinit_pkg::IDX_DIR_A);
	wire logic wr_db = wr & (idx == rcinit_pkg::IDX_DIR_B);
	wire logic wr_dc = wr & (idx == rcinit_pkg::IDX_DIR_C);
	wire logic wr_per = wr & (idx == rcinit_pkg::IDX_PERIOD);
	wire logic wr_bif = wr & (idx == rcinit_pkg::IDX_BIRQ_F);
	wire logic wr_bie = wr & (idx == rcinit_pkg::IDX_BIRQ_E);
	wire logic wr_bef = wr & (idx == rcinit_pkg::IDX_BERR_F);
	wire logic wr_bee = wr & (idx == rcinit_pkg::IDX_BERR_E);
	wire logic wr_est = wr & (idx == rcinit_pkg::IDX_EVT_ST);
	wire logic wr_msk = wr & (idx == rcinit_pkg::IDX_EVT_MASK);

	logic [7:0] rdata;
	always_comb begin
		unique case (idx)
			rcinit_pkg::IDX_STATUS: rdata = status_q;
			rcinit_pkg::IDX_CAUSE: rdata = {6'h00, pwr_cause_q}; // RULE13
			rcinit_pkg::IDX_CORE_IRQ: rdata = core_irq_q;
			rcinit_pkg::IDX_PIRQ_A: rdata = pirq_a_q;
			rcinit_pkg::IDX_PIRQ_B: rdata = {7'h00, pirq_b_q};
			rcinit_pkg::IDX_OPTION: rdata = option_q;
			rcinit_pkg::IDX_DIR_A: rdata = {2'h0, dir_a_q};
			rcinit_pkg::IDX_DIR_B: rdata = dir_b_q;
			rcinit_pkg::IDX_DIR_C: rdata = {3'h0, dir_c_q};
			rcinit_pkg::IDX_PERIOD: rdata = period_q;
			rcinit_pkg::IDX_BIRQ_F: rdata = {2'h0, birq_f_q};
			rcinit_pkg::IDX_BIRQ_E: rdata = {2'h0, birq_e_q};
			rcinit_pkg::IDX_BERR_F: rdata = berr_f_q;
			rcinit_pkg::IDX_BERR_E: rdata = berr_e_q;
			rcinit_pkg::IDX_EVT_ST: rdata = {3'h0, evt_st_q};
			rcinit_pkg::IDX_EVT_MASK: rdata = {3'h0, evt_mask_q};
			default: rdata = 8'h00;
		endcase
	end

	// status: time-out and power-down are hardware owned, software writes the rest
	always_comb begin
		status_d = status_q;
		if (wr_status) begin
			status_d = {wdat[7:5], status_q[4:3], wdat[2:0]};
		end
		unique case (cause)
			rcinit_pkg::C_NONE: ;
			rcinit_pkg::C_POWER_ON, rcinit_pkg::C_BROWNOUT:
				status_d = {3'h0, 2'b11, status_q[2:0]}; // RULE1 RULE2 RULE8
			rcinit_pkg::C_CLEAR_RUN:
				status_d = {3'h0, status_q[4:3], status_q[2:0]}; // RULE3 RULE9
			rcinit_pkg::C_CLEAR_SLEEP:
				status_d = {3'h0, 2'b10, status_q[2:0]}; // RULE4 RULE9
			rcinit_pkg::C_DOG_RUN:
				status_d = {3'h0, 2'b01, status_q[2:0]}; // RULE5 RULE9
			rcinit_pkg::C_DOG_SLEEP:
				status_d = {status_q[7:5], 2'b00, status_q[2:0]}; // RULE6
			rcinit_pkg::C_IRQ_WAKE:
				status_d = {status_q[7:5], 2'b10, status_q[2:0]}; // RULE7
		endcase
	end

	// cause register: cleared bit names the reset; other causes leave it alone
	always_comb begin
		pwr_cause_d = wr_cause ? wdat[1:0] : pwr_cause_q; // RULE14
		// a cause outranks a software write landing in the same cycle
		if (is_any) begin
			pwr_cause_d = pwr_cause_q; // RULE9
		end
		if (cause == rcinit_pkg::C_POWER_ON) begin
			pwr_cause_d[rcinit_pkg::CS_POWER_ON] = 1'b0; // RULE1
		end else if (cause == rcinit_pkg::C_BROWNOUT) begin
			pwr_cause_d[rcinit_pkg::CS_BROWNOUT] = 1'b0; // RULE8
		end
	end

	// restart address: resets go to zero, wake-ups resume or take the vector
	always_comb begin
		pc_d = rcinit_pkg::PC_RESET; // RULE1 RULE3 RULE4 RULE5 RULE8
		if (cause == rcinit_pkg::C_DOG_SLEEP) begin
			pc_d = pc_next; // RULE6
		end else if (cause == rcinit_pkg::C_IRQ_WAKE) begin
			pc_d = global_irq_enable ? rcinit_pkg::PC_VECTOR : pc_next; // RULE7
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lvl_prev_q <= 4'h0;
			status_q <= rcinit_pkg::STATUS_INIT;
			pwr_cause_q <= rcinit_pkg::CAUSE_INIT;
			pc_load_q <= 1'b0;
			pc_q <= rcinit_pkg::PC_RESET;
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
			irq_q <= 1'b0;
		end else begin
			lvl_prev_q <= lvl;
			status_q <= status_d;
			pwr_cause_q <= pwr_cause_d;
			pc_load_q <= is_any;
			pc_q <= is_any ? pc_d : pc_q;
			ack_q <= req & ~ack_q;
			dat_q <= (req & ~ack_q) ? {24'h00_0000, rdata} : dat_q;
			irq_q <= |(evt_st_q & evt_mask_q);
		end
	end

	// interrupt flags: cleared by resets except core bit 0, held through wake-up
	always_ff @(posedge clk_i) begin
		if (rst_i | is_reset) begin
			core_irq_q <= {7'h00, core_irq_q[0]};
			pirq_a_q <= rcinit_pkg::ZERO_INIT;
			pirq_b_q <= 1'b0;
		end else if (cause == rcinit_pkg::C_IRQ_WAKE && global_irq_enable) begin
			// taking the vector disables further interrupts, flags stay
			core_irq_q <= core_irq_q & ~(8'h01 << rcinit_pkg::CI_GLOBAL_EN); // RULE10
			pirq_a_q <= pirq_a_q; // RULE10
			pirq_b_q <= pirq_b_q;
		end else if (is_wake) begin
			core_irq_q <= core_irq_q; // RULE10
			pirq_a_q <= pirq_a_q;
			pirq_b_q <= pirq_b_q;
		end else begin
			core_irq_q <= rcinit_pkg::rcinit_sticky(core_irq_q, wr_core, wdat,
				{5'h00, core_flag_set_i});
			pirq_a_q <= rcinit_pkg::rcinit_sticky(pirq_a_q, wr_pa, wdat, pirq_a_set_i);
			pirq_b_q <= (wr_pb ? wdat[0] : pirq_b_q) | pirq_b_set_i;
		end
	end

	// configuration: forced to ones by resets, untouched by wake-up
	always_ff @(posedge clk_i) begin
		if (rst_i | is_reset) begin
			option_q <= rcinit_pkg::ONES_INIT; // RULE11
			dir_a_q <= rcinit_pkg::ONES_INIT[5:0]; // RULE11
			dir_b_q <= rcinit_pkg::ONES_INIT; // RULE11
			dir_c_q <= rcinit_pkg::ONES_INIT[4:0]; // RULE11
		end else begin
			option_q <= wr_opt ? wdat : option_q;
			dir_a_q <= wr_da ? wdat[5:0] : dir_a_q;
			dir_b_q <= wr_db ? wdat : dir_b_q;
			dir_c_q <= wr_dc ? wdat[4:0] : dir_c_q;
		end
	end

	// bus flags and enables, and the period, reinitialise on wake-up as well
	always_ff @(posedge clk_i) begin
		if (rst_i | is_any) begin
			period_q <= rcinit_pkg::ONES_INIT; // RULE12
			birq_f_q <= rcinit_pkg::ZERO_INIT[5:0]; // RULE12
			birq_e_q <= rcinit_pkg::ZERO_INIT[5:0];
			berr_f_q <= rcinit_pkg::ZERO_INIT;
			berr_e_q <= rcinit_pkg::ZERO_INIT;
		end else begin
			period_q <= wr_per ? wdat : period_q;
			birq_f_q <= (wr_bif ? wdat[5:0] : birq_f_q) | bus_irq_set_i;
			birq_e_q <= wr_bie ? wdat[5:0] : birq_e_q;
			berr_f_q <= rcinit_pkg::rcinit_sticky(berr_f_q, wr_bef, wdat, bus_err_set_i);
			berr_e_q <= wr_bee ? wdat : berr_e_q;
		end
	end

	// cause events: write one to clear, a new event in the same cycle wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			evt_st_q <= rcinit_pkg::ZERO_INIT[4:0];
			evt_mask_q <= rcinit_pkg::ZERO_INIT[4:0];
		end else begin
			evt_st_q <= (evt_st_q & ~(wr_est ? wdat[4:0] : 5'h00)) | evt;
			evt_mask_q <= wr_msk ? wdat[4:0] : evt_mask_q;
		end
	end

	assign dat_o = dat_q;
	assign ack_o = ack_q;
	assign pc_load_o = pc_load_q;
	assign pc_value_o = pc_q;
	assign global_irq_enable_o = global_irq_enable;
	assign option_o = option_q;
	assign port_a_direction_o = dir_a_q;
	assign port_b_direction_o = dir_b_q;
	assign port_c_direction_o = dir_c_q;
	assign timer_period_o = period_q;
	assign irq_o = irq_q;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_wake_vector;
		cause == rcinit_pkg::C_IRQ_WAKE && global_irq_enable;
	endsequence
	sequence s_wake_inline;
		cause == rcinit_pkg::C_IRQ_WAKE && !global_irq_enable;
	endsequence

	a_power_on_flags: assert property ( // RULE1
		cause == rcinit_pkg::C_POWER_ON |=> status_q[4:3] == 2'b11
			&& !pwr_cause_q[1] && pwr_cause_q[0] == $past(pwr_cause_q[0])
			&& pc_load_o && pc_value_o == 13'h0000)
		else $error("power-on flags or restart address wrong");
	a_powerdown_legal: assert property ( // RULE2
		$fell(pwr_cause_q[1]) |-> status_q[3] && status_q[4])
		else $error("power-on flag cleared without power-down and time-out set");
	a_clear_run_keep: assert property ( // RULE3
		cause == rcinit_pkg::C_CLEAR_RUN |=> status_q[7:5] == 3'h0
			&& status_q[4:3] == $past(status_q[4:3]) && pwr_cause_q == $past(pwr_cause_q)
			&& pc_value_o == 13'h0000)
		else $error("master clear while running changed kept flags");
	a_clear_sleep_flags: assert property ( // RULE4
		cause == rcinit_pkg::C_CLEAR_SLEEP |=> status_q[7:3] == 5'b00010
			&& pc_value_o == 13'h0000)
		else $error("master clear in sleep flags wrong");
	a_dog_run_flags: assert property ( // RULE5
		cause == rcinit_pkg::C_DOG_RUN |=> status_q[7:3] == 5'b00001
			&& pc_value_o == 13'h0000 && pc_load_o)
		else $error("watchdog reset flags wrong");
	a_dog_wake_resume: assert property ( // RULE6
		cause == rcinit_pkg::C_DOG_SLEEP |=> status_q[4:3] == 2'b00
			&& status_q[7:5] == $past(status_q[7:5]) && pc_value_o == $past(pc_next))
		else $error("watchdog wake-up flags or address wrong");
	a_irq_wake_vector: assert property ( // RULE7
		s_wake_vector |=> status_q[4:3] == 2'b10 && pc_value_o == 13'h0004 ##1 !pc_load_o)
		else $error("interrupt wake-up did not take the vector");
	a_irq_wake_inline: assert property ( // RULE7
		s_wake_inline |=> status_q[4:3] == 2'b10 && pc_value_o == $past(pc_next))
		else $error("interrupt wake-up did not resume in line");
	a_brownout_flags: assert property ( // RULE8
		cause == rcinit_pkg::C_BROWNOUT |=> !pwr_cause_q[0]
			&& pwr_cause_q[1] == $past(pwr_cause_q[1]) && status_q[7:5] == 3'h0)
		else $error("brown-out flags wrong");
	a_upper_cleared: assert property ( // RULE9
		is_reset && !is_power |=> status_q[7:5] == 3'h0 && pwr_cause_q == $past(pwr_cause_q))
		else $error("reset kept upper status or changed cause register");
	a_wake_flags_kept: assert property ( // RULE10
		is_wake |=> (($past(pirq_a_q) & ~pirq_a_q) == 8'h00) && ($past(pirq_b_q) <= pirq_b_q))
		else $error("wake-up cleared an interrupt flag");
	a_config_ones: assert property ( // RULE11
		is_reset |=> option_o == 8'hff && port_b_direction_o == 8'hff
			&& &port_a_direction_o && &port_c_direction_o)
		else $error("configuration not forced to ones");
	a_bus_flags_clear: assert property ( // RULE12
		is_any |=> birq_f_q == 6'h00 && berr_f_q == 8'h00 && birq_e_q == 6'h00
			&& berr_e_q == 8'h00 && timer_period_o == 8'hff)
		else $error("bus flags or period not reinitialised");
	a_cause_read_zero: assert property ( // RULE13
		ack_o && !we_i && $past(idx) == rcinit_pkg::IDX_CAUSE |-> dat_o[31:2] == 30'h0)
		else $error("cause register upper bits not zero");

endmodule : rcinit_top
`default_nettype wire

/* tb/rcinit_top_bench.sv */
// self-checking bench for the reset cause and initial value block
`timescale 1ns/100ps
`default_nettype none
module rcinit_top_bench;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
	logic [3:0] sel_i = 4'h1;
	logic [9:0] adr_i = 10'h000;
	logic [31:0] dat_i = 32'h0000_0000;
	logic [31:0] dat_o;
	logic ack_o, pc_load_o, global_irq_enable_o, irq_o;
	logic power_on_i = 1'b0, brownout_i = 1'b0, master_clear_pin_n_i = 1'b1;
	logic watchdog_timer_i = 1'b0, wake_irq_i = 1'b0, sleeping_i = 1'b0;
	logic [12:0] cur_pc_i = 13'h0123;
	logic [7:0] pirq_a_set_i = 8'h00;
	logic [5:0] bus_irq_set_i = 6'h00;
	logic [12:0] pc_value_o;
	logic [7:0] option_o, port_b_direction_o, timer_period_o;
	logic [5:0] port_a_direction_o;
	logic [4:0] port_c_direction_o;
	int fail_count = 0;
	int checks_done = 0;

	always #2 clk_i = ~clk_i;

	rcinit_top rcinit_top_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .sel_i(sel_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
		.ack_o(ack_o), .power_on_i(power_on_i), .brownout_i(brownout_i),
		.master_clear_pin_n_i(master_clear_pin_n_i), .watchdog_timer_i(watchdog_timer_i),
		.wake_irq_i(wake_irq_i), .sleeping_i(sleeping_i), .cur_pc_i(cur_pc_i),
		.core_flag_set_i(3'h0), .pirq_a_set_i(pirq_a_set_i), .pirq_b_set_i(1'b0),
		.bus_irq_set_i(bus_irq_set_i), .bus_err_set_i(8'h00), .pc_load_o(pc_load_o),
		.pc_value_o(pc_value_o), .global_irq_enable_o(global_irq_enable_o),
		.option_o(option_o), .port_a_direction_o(port_a_direction_o),
		.port_b_direction_o(port_b_direction_o), .port_c_direction_o(port_c_direction_o),
		.timer_period_o(timer_period_o), .irq_o(irq_o));

	task give_verdict;
		if (fail_count == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : give_verdict

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// classic single cycle; the wait is bounded so a dead slave cannot hang the run
	task wb(input logic w, input logic [9:0] a, input logic [7:0] wd, output logic [31:0] rd);
		int n;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= {24'h00_0000, wd};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		if (n >= 50)
			chk("ack", 32'h1, 32'h0);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
	endtask : wb

	task wr(input logic [9:0] a, input logic [7:0] d);
		logic [31:0] r;
		wb(1'b1, a, d, r);
	endtask : wr

	task rdc(input string nm, input logic [9:0] a, input logic [7:0] exp);
		logic [31:0] r;
		wb(1'b0, a, 8'h00, r);
		chk(nm, {24'h00_0000, exp}, r);
	endtask : rdc

	task set_src(input int k, input logic v);
		case (k)
			0: power_on_i <= v;
			1: brownout_i <= v;
			2: master_clear_pin_n_i <= ~v;
			3: watchdog_timer_i <= v;
			default: wake_irq_i <= v;
		endcase
	endtask : set_src

	// async sources held five cycles to pass the synchroniser; wake is a one-cycle level
	task fire(input int k, input int exp_n, input logic [12:0] exp_pc);
		int n;
		int seen;
		seen = 0;
		@(posedge clk_i);
		set_src(k, 1'b1);
		for (n = 0; n < 12; n++) begin
			@(posedge clk_i);
			if ((k == 4 && n == 0) || n == 4)
				set_src(k, 1'b0);
			if (pc_load_o === 1'b1) begin
				seen++;
				chk("pc_value", {19'h0, exp_pc}, {19'h0, pc_value_o});
			end
		end
		chk("pc_loads", exp_n, seen);
	endtask : fire

	task t_reset;
		rdc("status", 10'h00c, 8'h18);
		rdc("cause", 10'h238, 8'h00);
		chk("option", 32'hff, {24'h0, option_o});
		chk("dirs", {13'h0, 6'h3f, 8'hff, 5'h1f}, {13'h0, port_a_direction_o,
			port_b_direction_o, port_c_direction_o});
		chk("period", 32'hff, {24'h0, timer_period_o});
		rdc("unmapped", 10'h3fc, 8'h00);
		wr(10'h238, 8'hff);
		rdc("cause_upper", 10'h238, 8'h03);
	endtask : t_reset

	task t_power_brown;
		wr(10'h00c, 8'hff);
		wr(10'h204, 8'h12);
		fire(0, 1, 13'h0000);
		rdc("status_por", 10'h00c, 8'h1f);
		rdc("cause_por", 10'h238, 8'h01);
		chk("option_por", 32'hff, {24'h0, option_o});
		wr(10'h238, 8'h03);
		wr(10'h00c, 8'hff);
		fire(1, 1, 13'h0000);
		rdc("status_bor", 10'h00c, 8'h1f);
		rdc("cause_bor", 10'h238, 8'h02);
	endtask : t_power_brown

	task t_run_resets;
		wr(10'h00c, 8'he7);
		fire(3, 1, 13'h0000);
		rdc("status_dog", 10'h00c, 8'h0f);
		rdc("cause_dog", 10'h238, 8'h02);
		wr(10'h00c, 8'he5);
		fire(2, 1, 13'h0000);
		rdc("status_clr", 10'h00c, 8'h0d);
		rdc("cause_clr", 10'h238, 8'h02);
	endtask : t_run_resets

	task t_sleep_resets;
		wr(10'h204, 8'h5a);
		wr(10'h214, 8'h05);
		sleeping_i <= 1'b1;
		fire(2, 1, 13'h0000);
		sleeping_i <= 1'b0;
		rdc("status_clr_slp", 10'h00c, 8'h15);
		chk("option_clr", 32'hff, {24'h0, option_o});
		chk("dir_a_clr", 32'h3f, {26'h0, port_a_direction_o});
		wr(10'h00c, 8'he2);
		wr(10'h204, 8'h5a);
		wr(10'h214, 8'h05);
		wr(10'h248, 8'h33);
		sleeping_i <= 1'b1;
		fire(3, 1, 13'h0124);
		sleeping_i <= 1'b0;
		rdc("status_dog_slp", 10'h00c, 8'he2);
		chk("option_wake", 32'h5a, {24'h0, option_o});
		chk("dir_a_wake", 32'h05, {26'h0, port_a_direction_o});
		chk("period_wake", 32'hff, {24'h0, timer_period_o});
	endtask : t_sleep_resets

	task t_wake;
		fire(4, 0, 13'h0000);
		wr(10'h02c, 8'h00);
		wr(10'h284, 8'h3f);
		@(posedge clk_i);
		pirq_a_set_i <= 8'h04;
		bus_irq_set_i <= 6'h3f;
		@(posedge clk_i);
		pirq_a_set_i <= 8'h00;
		bus_irq_set_i <= 6'h00;
		rdc("bus_flags_set", 10'h280, 8'h3f);
		sleeping_i <= 1'b1;
		fire(4, 1, 13'h0124);
		rdc("status_wake", 10'h00c, 8'hf2);
		rdc("pirq_a_wake", 10'h030, 8'h04);
		rdc("bus_flags_wake", 10'h280, 8'h00);
		rdc("bus_en_wake", 10'h284, 8'h00);
		wr(10'h02c, 8'h80);
		// the write lands at the ack edge; look once it has settled
		@(posedge clk_i);
		chk("gie_set", 32'h1, {31'h0, global_irq_enable_o});
		fire(4, 1, 13'h0004);
		sleeping_i <= 1'b0;
		chk("gie_vector", 32'h0, {31'h0, global_irq_enable_o});
	endtask : t_wake

	// sticky events, mask and write-one-to-clear
	task t_irq;
		rdc("evt_status", 10'h300, 8'h1f);
		chk("irq_masked", 32'h0, {31'h0, irq_o});
		wr(10'h304, 8'h08);
		repeat (2) @(posedge clk_i);
		chk("irq_on", 32'h1, {31'h0, irq_o});
		wr(10'h300, 8'h08);
		repeat (2) @(posedge clk_i);
		chk("irq_off", 32'h0, {31'h0, irq_o});
		rdc("evt_cleared", 10'h300, 8'h17);
	endtask : t_irq

	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_power_brown();
		t_run_resets();
		t_sleep_resets();
		t_wake();
		t_irq();
		give_verdict();
	end

	// the whole sequence needs well under two thousand cycles
	initial begin
		#40000;
		fail_count++;
		give_verdict();
	end
endmodule : rcinit_top_bench
`default_nettype wire
